// file: core/gpij_defines.svh
// Register offsets, field positions and reset values of the port block
`ifndef GPIJ_DEFINES_SVH
`define GPIJ_DEFINES_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define GPIJ_OFF_PJ_DATA   8'h00
`define GPIJ_OFF_PJ_OE     8'h04
`define GPIJ_OFF_PJ_FS     8'h08
`define GPIJ_OFF_RSVD      8'h10
`define GPIJ_OFF_PJ_PU     8'h2c
`define GPIJ_OFF_PJ_IE     8'h38
`define GPIJ_OFF_PI_FS     8'h48
`define GPIJ_OFF_PI_PU     8'h6c
`define GPIJ_OFF_PI_IE     8'h78

// ---------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------
`define GPIJ_PORT_W        8
`define GPIJ_RST_BYTE      8'h00
`define GPIJ_RST_WORD      32'h0000_0000
`define GPIJ_PJ_IRQ_BITS   8'hcf
`define GPIJ_PJ_TMR_BITS   8'h30
`define GPIJ_PI_TMR_BITS   8'h3f
`define GPIJ_PI_CAP_HI     7
`define GPIJ_PI_CAP_LO     6
`define GPIJ_HTRANS_NSEQ   2'h2

`endif

// file: core/gpij_pkg.sv
// Types shared by the port block
package gpij_pkg;
	// One port's worth of bits
	typedef logic [7:0] gpij_byte_type;
	// One bus word
	typedef logic [31:0] gpij_word_type;
	// Register selected by a bus address
	typedef enum logic [3:0] {
		GPIJ_SEL_NONE    = 4'h0,
		GPIJ_SEL_PJ_DATA = 4'h1,
		GPIJ_SEL_PJ_OE   = 4'h2,
		GPIJ_SEL_PJ_FS   = 4'h3,
		GPIJ_SEL_PJ_PU   = 4'h4,
		GPIJ_SEL_PJ_IE   = 4'h5,
		GPIJ_SEL_PI_FS   = 4'h6,
		GPIJ_SEL_PI_PU   = 4'h7,
		GPIJ_SEL_PI_IE   = 4'h8
	} gpij_sel_type;
endpackage

// file: core/gpij_top.sv
// Port J and Port I control block with a bus register slave
`timescale 1ns/100ps
`include "gpij_defines.svh"

module gpij_top
	import gpij_pkg::*;
(
	// Clock and reset
	input  wire logic          CLOCK_I,
	input  wire logic          RESETN_I,
	// Bus slave
	input  wire logic          HSEL_I,
	input  wire logic [31:0]   HADDR_I,
	input  wire logic [1:0]    HTRANS_I,
	input  wire logic          HWRITE_I,
	input  wire logic [2:0]    HSIZE_I,
	input  wire logic [31:0]   HWDATA_I,
	input  wire logic          HREADY_I,
	output logic [31:0]        HRDATA_O,
	output logic               HREADYOUT_O,
	output logic               HRESP_O,
	// Clock/mode block status
	input  wire logic          STOP_MODE_I,
	input  wire logic          STOP_DRIVE_HALT_I,
	// Timer outputs 7 to 0
	input  wire logic [7:0]    TIMER_OUT_I,
	// Port I data and drive from the left-out registers
	input  wire logic [7:0]    PI_DATA_I,
	input  wire logic [7:0]    PI_DRIVE_I,
	// Port J pins
	input  wire logic [7:0]    PJ_PIN_I,
	output logic [7:0]         PJ_PIN_O,
	output logic [7:0]         PJ_PIN_OE_O,
	output logic [7:0]         PJ_PULLUP_O,
	output logic [7:0]         PJ_INBUF_O,
	output logic [7:0]         PJ_IN_O,
	// Port I pins
	input  wire logic [7:0]    PI_PIN_I,
	output logic [7:0]         PI_PIN_O,
	output logic [7:0]         PI_PIN_OE_O,
	output logic [7:0]         PI_PULLUP_O,
	output logic [7:0]         PI_INBUF_O,
	output logic [7:0]         PI_IN_O,
	// Interrupt and capture routing
	output logic [7:0]         EXT_IRQ_O,
	output logic [1:0]         TIMER4_CAPTURE_O
);

	// -----------------------------------------------------------
	// Reset synchroniser
	// -----------------------------------------------------------
	logic          rst_s1_r;   // First stage, read by second only
	logic          rst_n_r;    // Released reset used everywhere

	// Asynchronous assert, two-edge release
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// -----------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------
	gpij_sel_type  addr_sel;   // Register hit by the address phase
	logic          take;       // Address phase accepted this edge

	// Map word address to register
	function automatic gpij_sel_type dec(input logic [7:0] a);
		gpij_sel_type s;
		s = GPIJ_SEL_NONE;
		if ({a[7:2], 2'h0} == `GPIJ_OFF_PJ_DATA)
			s = GPIJ_SEL_PJ_DATA;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PJ_OE)
			s = GPIJ_SEL_PJ_OE;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PJ_FS)
			s = GPIJ_SEL_PJ_FS;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PJ_PU)
			s = GPIJ_SEL_PJ_PU;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PJ_IE)
			s = GPIJ_SEL_PJ_IE;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PI_FS)
			s = GPIJ_SEL_PI_FS;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PI_PU)
			s = GPIJ_SEL_PI_PU;
		else if ({a[7:2], 2'h0} == `GPIJ_OFF_PI_IE)
			s = GPIJ_SEL_PI_IE;
		// Reserved and unmapped words stay NONE
		return s;
	endfunction

	assign addr_sel = dec(HADDR_I[7:0]);
	assign take     = HSEL_I && HREADY_I &&
	                  (HTRANS_I == `GPIJ_HTRANS_NSEQ);

	// -----------------------------------------------------------
	// Write data phase
	// -----------------------------------------------------------
	logic          wr_pend_r;  // Write data phase in progress
	gpij_sel_type  wr_sel_r;   // Register being written

	// Capture a write address phase
	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wr_pend_r <= 1'b0;
			wr_sel_r  <= GPIJ_SEL_NONE;
		end else begin
			wr_pend_r <= take && HWRITE_I;
			wr_sel_r  <= addr_sel;
		end
	end

	// -----------------------------------------------------------
	// Register file
	// -----------------------------------------------------------
	gpij_byte_type pj_data_r, pj_data_nxt;  // Port J data
	gpij_byte_type pj_oe_r,   pj_oe_nxt;    // Port J output enable
	gpij_byte_type pj_fs_r,   pj_fs_nxt;    // Port J function select
	gpij_byte_type pj_pu_r,   pj_pu_nxt;    // Port J pull-up
	gpij_byte_type pj_ie_r,   pj_ie_nxt;    // Port J input enable
	gpij_byte_type pi_fs_r,   pi_fs_nxt;    // Port I function select
	gpij_byte_type pi_pu_r,   pi_pu_nxt;    // Port I pull-up
	gpij_byte_type pi_ie_r,   pi_ie_nxt;    // Port I input enable
	gpij_byte_type wbyte;                   // Low byte of write data

	assign wbyte = HWDATA_I[7:0];

	// Next values; upper write bits are dropped
	always_comb begin
		pj_data_nxt = pj_data_r;
		pj_oe_nxt   = pj_oe_r;
		pj_fs_nxt   = pj_fs_r;
		pj_pu_nxt   = pj_pu_r;
		pj_ie_nxt   = pj_ie_r;
		pi_fs_nxt   = pi_fs_r;
		pi_pu_nxt   = pi_pu_r;
		pi_ie_nxt   = pi_ie_r;
		if (wr_pend_r) begin
			unique case (wr_sel_r)
				GPIJ_SEL_PJ_DATA: pj_data_nxt = wbyte;
				GPIJ_SEL_PJ_OE:   pj_oe_nxt   = wbyte;
				GPIJ_SEL_PJ_FS:   pj_fs_nxt   = wbyte;
				GPIJ_SEL_PJ_PU:   pj_pu_nxt   = wbyte;
				GPIJ_SEL_PJ_IE:   pj_ie_nxt   = wbyte;
				GPIJ_SEL_PI_FS:   pi_fs_nxt   = wbyte;
				GPIJ_SEL_PI_PU:   pi_pu_nxt   = wbyte;
				GPIJ_SEL_PI_IE:   pi_ie_nxt   = wbyte;
				// Unmapped writes are dropped
				GPIJ_SEL_NONE:    ;
				default:          ;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pj_data_r <= `GPIJ_RST_BYTE;
			pj_oe_r   <= `GPIJ_RST_BYTE;
			pj_fs_r   <= `GPIJ_RST_BYTE;
			pj_pu_r   <= `GPIJ_RST_BYTE;
			pj_ie_r   <= `GPIJ_RST_BYTE;
			pi_fs_r   <= `GPIJ_RST_BYTE;
			pi_pu_r   <= `GPIJ_RST_BYTE;
			pi_ie_r   <= `GPIJ_RST_BYTE;
		end else begin
			pj_data_r <= pj_data_nxt;
			pj_oe_r   <= pj_oe_nxt;
			pj_fs_r   <= pj_fs_nxt;
			pj_pu_r   <= pj_pu_nxt;
			pj_ie_r   <= pj_ie_nxt;
			pi_fs_r   <= pi_fs_nxt;
			pi_pu_r   <= pi_pu_nxt;
			pi_ie_r   <= pi_ie_nxt;
		end
	end

	// -----------------------------------------------------------
	// Read data and response
	// -----------------------------------------------------------
	gpij_byte_type rbyte;      // Selected register, write forwarded

	// Read from next values so a write just before is seen
	always_comb begin
		unique case (addr_sel)
			GPIJ_SEL_PJ_DATA: rbyte = pj_data_nxt;
			GPIJ_SEL_PJ_OE:   rbyte = pj_oe_nxt;
			GPIJ_SEL_PJ_FS:   rbyte = pj_fs_nxt;
			GPIJ_SEL_PJ_PU:   rbyte = pj_pu_nxt;
			GPIJ_SEL_PJ_IE:   rbyte = pj_ie_nxt;
			GPIJ_SEL_PI_FS:   rbyte = pi_fs_nxt;
			GPIJ_SEL_PI_PU:   rbyte = pi_pu_nxt;
			GPIJ_SEL_PI_IE:   rbyte = pi_ie_nxt;
			GPIJ_SEL_NONE:    rbyte = `GPIJ_RST_BYTE;
			default:          rbyte = `GPIJ_RST_BYTE;
		endcase
	end

	// Upper bits read zero; no wait states
	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			HRDATA_O    <= `GPIJ_RST_WORD;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			if (take && !HWRITE_I)
				HRDATA_O <= {24'h00_0000, rbyte};
			else
				HRDATA_O <= `GPIJ_RST_WORD;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// Pin input synchronisers
	// -----------------------------------------------------------
	gpij_byte_type pj_s1_r;    // Port J first stage
	gpij_byte_type pj_s2_r;    // Port J second stage
	gpij_byte_type pi_s1_r;    // Port I first stage
	gpij_byte_type pi_s2_r;    // Port I second stage

	// Two flops before any pin is read
	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pj_s1_r <= `GPIJ_RST_BYTE;
			pj_s2_r <= `GPIJ_RST_BYTE;
			pi_s1_r <= `GPIJ_RST_BYTE;
			pi_s2_r <= `GPIJ_RST_BYTE;
		end else begin
			pj_s1_r <= PJ_PIN_I;
			pj_s2_r <= pj_s1_r;
			pi_s1_r <= PI_PIN_I;
			pi_s2_r <= pi_s1_r;
		end
	end

	// -----------------------------------------------------------
	// Pin function logic
	// -----------------------------------------------------------
	logic          halt;       // Stop mode with pin drive halted
	gpij_byte_type pj_in;      // Port J input after buffer gate
	gpij_byte_type pi_in;      // Port I input after buffer gate
	gpij_byte_type pj_tsel;    // Port J pins driven by a timer
	gpij_byte_type pi_tsel;    // Port I pins driven by a timer
	gpij_byte_type pj_tmr;     // Timers 7,6 placed on pins 5,4
	gpij_byte_type irq_gate;   // Pins allowed to raise interrupts

	assign halt = STOP_MODE_I && STOP_DRIVE_HALT_I;

	assign pj_in = pj_s2_r & pj_ie_r;
	assign pi_in = pi_s2_r & pi_ie_r;

	assign pj_tsel = pj_fs_r & `GPIJ_PJ_TMR_BITS;
	assign pj_tmr  = {2'h0, TIMER_OUT_I[7:6], 4'h0};
	assign pi_tsel = pi_fs_r & `GPIJ_PI_TMR_BITS;

	// In halted stop only selected, enabled pins pass
	// Otherwise input enable alone passes the pin
	assign irq_gate = halt ? (pj_ie_r & pj_fs_r) : pj_ie_r;

	// Per-bit Port J drive and direction
	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			PJ_PIN_O    <= `GPIJ_RST_BYTE;
			PJ_PIN_OE_O <= `GPIJ_RST_BYTE;
			PJ_PULLUP_O <= `GPIJ_RST_BYTE;
			PJ_INBUF_O  <= `GPIJ_RST_BYTE;
			PJ_IN_O     <= `GPIJ_RST_BYTE;
		end else begin
			PJ_PIN_O    <= (pj_tmr & pj_tsel) |
			               (pj_data_r & ~pj_tsel);
			// Driver follows enable, cut by halt
			PJ_PIN_OE_O <= halt ? `GPIJ_RST_BYTE : pj_oe_r;
			// Pull-up and buffer to the pads
			PJ_PULLUP_O <= pj_pu_r;
			PJ_INBUF_O  <= pj_ie_r;
			PJ_IN_O     <= pj_in;
		end
	end

	// Port I drive, pads and input
	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			PI_PIN_O    <= `GPIJ_RST_BYTE;
			PI_PIN_OE_O <= `GPIJ_RST_BYTE;
			PI_PULLUP_O <= `GPIJ_RST_BYTE;
			PI_INBUF_O  <= `GPIJ_RST_BYTE;
			PI_IN_O     <= `GPIJ_RST_BYTE;
		end else begin
			PI_PIN_O    <= (TIMER_OUT_I & pi_tsel) |
			               (PI_DATA_I & ~pi_tsel);
			PI_PIN_OE_O <= halt ? `GPIJ_RST_BYTE : PI_DRIVE_I;
			PI_PULLUP_O <= pi_pu_r;
			PI_INBUF_O  <= pi_ie_r;
			PI_IN_O     <= pi_in;
		end
	end

	always_ff @(posedge CLOCK_I or negedge rst_n_r) begin
		if (!rst_n_r) begin
			EXT_IRQ_O        <= `GPIJ_RST_BYTE;
			TIMER4_CAPTURE_O <= 2'h0;
		end else begin
			EXT_IRQ_O <= pj_in & irq_gate & `GPIJ_PJ_IRQ_BITS;
			// Pins 7,6 to capture inputs 1,0
			TIMER4_CAPTURE_O <= {
				pi_in[`GPIJ_PI_CAP_HI] & pi_fs_r[`GPIJ_PI_CAP_HI],
				pi_in[`GPIJ_PI_CAP_LO] & pi_fs_r[`GPIJ_PI_CAP_LO]};
		end
	end

endmodule

// file: sim/gpij_monitor.sv
// Concurrent checks on the port block's top-level pins
`timescale 1ns/100ps

module gpij_monitor (
	// Clock, reset and bus
	input wire logic        CLOCK_I,
	input wire logic        RESETN_I,
	input wire logic        HSEL_I,
	input wire logic [1:0]  HTRANS_I,
	input wire logic        HWRITE_I,
	input wire logic [31:0] HRDATA_O,
	input wire logic        HREADYOUT_O,
	input wire logic        HRESP_O,
	// Mode and Port I drive
	input wire logic        STOP_MODE_I,
	input wire logic        STOP_DRIVE_HALT_I,
	input wire logic [7:0]  PI_DRIVE_I,
	// Pin side
	input wire logic [7:0]  PJ_PIN_OE_O,
	input wire logic [7:0]  PJ_INBUF_O,
	input wire logic [7:0]  PJ_IN_O,
	input wire logic [7:0]  PI_PIN_OE_O,
	input wire logic [7:0]  PI_INBUF_O,
	input wire logic [7:0]  PI_IN_O,
	input wire logic [7:0]  EXT_IRQ_O,
	input wire logic [1:0]  TIMER4_CAPTURE_O
);
	logic [1:0] up_r; // Edges since release, saturating
	wire        halt = STOP_MODE_I && STOP_DRIVE_HALT_I;

	// Internal reset lasts two edges past release
	always_ff @(posedge CLOCK_I or negedge RESETN_I)
		if (!RESETN_I)
			up_r <= 2'h0;
		else if (up_r != 2'h3)
			up_r <= up_r + 2'h1;

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESETN_I);

	chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
		else $error("bus answer not ready and okay");
	chk_rd_upper: assert property (HRDATA_O[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_rd_idle: assert property
		(!(HSEL_I && HTRANS_I == 2'h2 && !HWRITE_I) |=> HRDATA_O == 32'h0)
		else $error("read data outside a read");
	chk_halt_drive: assert property (halt |=>
		PJ_PIN_OE_O == 8'h00 && PI_PIN_OE_O == 8'h00)
		else $error("pin driven in halted stop");
	chk_pj_gate: assert property ((PJ_IN_O & ~PJ_INBUF_O) == 8'h00)
		else $error("disabled input not held low");
	chk_pi_gate: assert property ((PI_IN_O & ~PI_INBUF_O) == 8'h00)
		else $error("disabled port i input not low");
	chk_irq_gate: assert property
		((EXT_IRQ_O & ~PJ_INBUF_O & ~$past(PJ_INBUF_O)) == 8'h00)
		else $error("interrupt without input enable");
	chk_irq_unused: assert property (EXT_IRQ_O[5:4] == 2'h0)
		else $error("timer pins raised an interrupt");
	chk_pi_drive: assert property (up_r == 2'h3 && !halt |=>
		PI_PIN_OE_O == $past(PI_DRIVE_I))
		else $error("port i enable does not follow drive");
	chk_cap_gate: assert property ((TIMER4_CAPTURE_O &
		~PI_INBUF_O[7:6] & ~$past(PI_INBUF_O[7:6])) == 2'h0)
		else $error("capture without input enable");

	cover property (halt && EXT_IRQ_O != 8'h00);
	cover property (TIMER4_CAPTURE_O != 2'h0);
	cover property (PJ_PIN_OE_O == 8'hff);
endmodule

bind gpij_top gpij_monitor u_gpij_monitor (.*);

// file: sim/gpij_pads.sv
// Pad and far-side driver model for one eight-pin port
`timescale 1ns/100ps

module gpij_pads (
	input  wire logic       clk_i,
	input  wire logic [7:0] out_i,    // Block pin value
	input  wire logic [7:0] oe_i,     // Block drives pin
	input  wire logic [7:0] pu_i,     // Pull-up on
	input  wire logic [7:0] ext_i,    // Far-side value
	input  wire logic [7:0] ext_en_i, // Far side drives pin
	output logic [7:0]      pad_o     // Resolved level
);
	logic [7:0] flt_r = 8'h5a; // Floating pins wander each cycle

	always_ff @(posedge clk_i)
		flt_r <= ~flt_r;

	assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
		| (~oe_i & ~ext_en_i & (pu_i | flt_r));
endmodule

// file: sim/test_gpij_top.sv
// Self-checking bench for the port block
`timescale 1ns/100ps
`include "gpij_defines.svh"

module test_gpij_top
	import gpij_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp;
	logic stop = 1'b0, halt = 1'b0, rd_ph = 1'b0;
	logic [1:0] htrans = 2'h0, cap;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [7:0] tmr = 8'h0, pid = 8'h0, pidrv = 8'h0, ext = 8'h0;
	logic [7:0] exten = 8'h0, jo, joe, jpu, jib, jin, jpad;
	logic [7:0] io, ioe, ipu, iib, iin, ipad, irq, d, t;
	// reserved word never touched; data register twice
	logic [7:0] ad [9] = '{8'h00, 8'h04, 8'h08, 8'h2c, 8'h38,
		`GPIJ_OFF_PI_FS, `GPIJ_OFF_PI_PU, `GPIJ_OFF_PI_IE, 8'h00};
	gpij_word_type wv [9];
	gpij_word_type exp_q [$];
	int fail_count = 0, compares = 0, seed = 89077;

	initial forever #2.5 clk = ~clk;

	gpij_top u_gpij_top (.CLOCK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
		.HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
		.STOP_MODE_I(stop), .STOP_DRIVE_HALT_I(halt), .TIMER_OUT_I(tmr),
		.PI_DATA_I(pid), .PI_DRIVE_I(pidrv), .PJ_PIN_I(jpad),
		.PJ_PIN_O(jo), .PJ_PIN_OE_O(joe), .PJ_PULLUP_O(jpu),
		.PJ_INBUF_O(jib), .PJ_IN_O(jin), .PI_PIN_I(ipad), .PI_PIN_O(io),
		.PI_PIN_OE_O(ioe), .PI_PULLUP_O(ipu), .PI_INBUF_O(iib),
		.PI_IN_O(iin), .EXT_IRQ_O(irq), .TIMER4_CAPTURE_O(cap));
	gpij_pads u_gpij_pads (.clk_i(clk), .out_i(jo), .oe_i(joe),
		.pu_i(jpu), .ext_i(ext), .ext_en_i(exten), .pad_o(jpad));
	gpij_pads u_gpij_pads_i (.clk_i(clk), .out_i(io), .oe_i(ioe),
		.pu_i(ipu), .ext_i(8'h00), .ext_en_i(8'h00), .pad_o(ipad));

	// Compare one value and count it
	task automatic check(input string n, input gpij_word_type s, e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask

	// One single bus transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [7:0] a,
		input gpij_word_type wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (!hrdy) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rd_ph <= !w;
		@(posedge clk);
		while (!hrdy) @(posedge clk);
		rd_ph <= 1'b0;
	endtask

	// Read with its expected word noted for the watcher
	task automatic rd(input logic [7:0] a, input gpij_word_type e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask

	// Let outputs settle past the latest edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrap_up;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watcher takes the oldest note at each read data phase
	always @(posedge clk)
		if (rd_ph)
			check("hrdata", hrdata, exp_q.pop_front());

	initial begin
		#50000;
		fail_count++;
		wrap_up;
	end

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		// Internal reset ends two edges after release
		repeat (3) @(posedge clk);
		for (int i = 0; i < 9; i++)
			rd(ad[i], 32'h0);
		check("reset pins", {joe, jpu, jib, irq}, 32'h0);
		// write then read back each register
		for (int i = 0; i < 9; i++) begin
			wv[i] = $random(seed);
			xfer(1'b1, ad[i], wv[i]);
			rd(ad[i], {24'h0, wv[i][7:0]});
		end
		wt(1);
		check("ctl", {jpu, jib, ipu, iib},
			{wv[3][7:0], wv[4][7:0], wv[6][7:0], wv[7][7:0]});
		// data, enable and timer on pins
		for (int k = 0; k < 4; k++) begin
			d = 8'($random(seed));
			t = 8'($random(seed));
			tmr <= t;
			xfer(1'b1, 8'h00, {24'hffffff, d});
			xfer(1'b1, 8'h04, 32'hff);
			xfer(1'b1, 8'h08, 32'h0);
			xfer(1'b1, 8'h38, 32'hff);
			wt(6);
			check("loop", {jo, joe, jin}, {8'h0, d, 8'hff, d});
			xfer(1'b1, 8'h08, 32'h30);
			wt(6);
			check("tmr", {jo, irq}, {d[7:6], t[7:6], d[3:0], d & 8'hcf});
		end
		pid <= d;
		pidrv <= 8'hff;
		xfer(1'b1, `GPIJ_OFF_PI_FS, 32'hff);
		xfer(1'b1, `GPIJ_OFF_PI_IE, 32'hff);
		wt(6);
		check("pi", {io, iin, cap}, {d[7:6], t[5:0], d[7:6], t[5:0], d[7:6]});
		xfer(1'b1, 8'h04, 32'h0);
		ext <= 8'hff;
		exten <= 8'hff;
		// unused pins 7-4 keep input off
		xfer(1'b1, 8'h38, 32'h0f);
		xfer(1'b1, 8'h08, 32'hc3);
		wt(6);
		check("irq", irq, 32'h0f);
		stop <= 1'b1;
		halt <= 1'b1;
		wt(3);
		check("stop", {irq, joe, ioe}, {8'h03, 16'h0});
		halt <= 1'b0;
		wt(3);
		check("nohalt", irq, 32'h0f);
		stop <= 1'b0;
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// First request only once internal reset is gone
		repeat (3) @(posedge clk);
		rd(8'h38, 32'h0);
		rd(8'h08, 32'h0);
		wt(2);
		wrap_up;
	end
endmodule
